// ==== design/ivp_pkg.sv ====
// Purpose: constants and types for the interrupt vector placement block
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: register map reached over AXI4-Lite
// Notes on behaviour
// - select bit zero puts vectors at the start of program flash
// - select bit one moves vectors to the boot section start
// - boot section start address comes from the boot size fuses
// - interrupts masked from enable set until after the next instruction
// - without a select write, masking lasts four cycles then ends
// - automatic masking never alters the global interrupt enable bit
// - change enable clears after four cycles or on the select write
// - boot vectors with app lock: block interrupts in application code
// - app vectors with boot lock: block interrupts in boot code
// - control resets to zero; bits 7,4,1,0 writable, 6,5,3,2 read-only
package ivp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h93;
  localparam int CHG_BIT = 0;
  localparam int SEL_BIT = 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WINDOW_CYCLES = 4;
  localparam int INSTR_CYCLES = 1;
  localparam logic [2:0] WINDOW_CNT = 3'(WINDOW_CYCLES);
  localparam logic [2:0] TAIL_CNT = 3'(INSTR_CYCLES);

  // ---------------------------------------------------------------
  // flash geometry
  // ---------------------------------------------------------------
  localparam int PC_W = 14;
  localparam logic [PC_W-1:0] FLASH_TOP = 14'h3FFF;
  localparam logic [PC_W-1:0] APP_BASE = 14'h0000;
  localparam logic [PC_W-1:0] BOOT_WORDS_MIN = 14'h0100;

  typedef enum logic [1:0] {
    MASK_IDLE,
    MASK_WINDOW,
    MASK_TAIL
  } mask_state_t;

  typedef struct packed {
    logic [1:0] bootSize;
    logic appLock;
    logic bootLock;
  } fuse_t;

  typedef struct packed {
    logic irqBlock;
    logic inBoot;
    logic [PC_W-1:0] vectorBase;
  } vec_out_t;

endpackage

// ==== design/boot_base.sv ====
// Purpose: boot section start address from boot size fuses
// Assumes: fuses static during operation
// Notes: larger fuse code gives a smaller boot section
`timescale 1ns/10ps
module boot_base
  import ivp_pkg::*;
(
  input wire logic [1:0] bootSize,
  output logic [PC_W-1:0] bootStart
);

  logic [PC_W-1:0] words;

  always_comb
  begin
    words = BOOT_WORDS_MIN << (2'd3 - bootSize);
    bootStart = FLASH_TOP - words + 14'h0001;
  end

endmodule

// ==== design/interrupt_vector_placement.sv ====
// Purpose: interrupt vector table placement with timed change sequence
// Assumes: AXI4-Lite register access, core reports its program counter
// Notes: irqBlock gates interrupts without touching the global enable
`timescale 1ns/10ps
module interrupt_vector_placement
  import ivp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire fuse_t fuses,
  input wire logic [PC_W-1:0] corePc,
  input wire logic instrDone,
  output vec_out_t vecOut,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [3:0] awAddr_q;
  logic [7:0] wData_q;
  logic wStrb_q;
  logic wrFire;
  logic ctrlWr;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end
    else if (wrFire)
      awHeld_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wHeld_q <= 1'b0;
      wData_q <= 8'h00;
      wStrb_q <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_q <= 1'b1;
      wData_q <= s_axi_wdata[7:0];
      wStrb_q <= s_axi_wstrb[0];
    end
    else if (wrFire)
      wHeld_q <= 1'b0;
  end

  // ready from a flop: next held and response state decoded ahead
  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_axi_awready <= 1'b0;
    else
      s_axi_awready <= ~(s_axi_awvalid & s_axi_awready) & ~awHeld_q &
                       ~(s_axi_bvalid & ~s_axi_bready);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_axi_wready <= 1'b0;
    else
      s_axi_wready <= ~(s_axi_wvalid & s_axi_wready) & ~wHeld_q &
                      ~(s_axi_bvalid & ~s_axi_bready);
  end

  assign wrFire = awHeld_q & wHeld_q;
  assign ctrlWr = wrFire & wStrb_q & (awAddr_q[3:2] == CTRL_ADDR[3:2]);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else if (wrFire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_q[3:2] == CTRL_ADDR[3:2] ||
                      awAddr_q[3:2] == STAT_ADDR[3:2]) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // control register and change window
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [2:0] winCnt_q;
  logic chgSet;
  logic selWr;
  logic winOpen;

  assign winOpen = ctrl_q[CHG_BIT];
  // write with change enable one opens the window
  assign chgSet = ctrlWr & wData_q[CHG_BIT];
  assign selWr = ctrlWr & ~wData_q[CHG_BIT] & winOpen;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_q <= CTRL_RESET;
    else
    begin
      if (ctrlWr)
        ctrl_q[7] <= wData_q[7];
      if (ctrlWr)
        ctrl_q[4] <= wData_q[4];
      if (selWr)
        ctrl_q[SEL_BIT] <= wData_q[SEL_BIT];
      if (chgSet)
        ctrl_q[CHG_BIT] <= 1'b1;
      else if (selWr || winCnt_q == 3'h1)
        ctrl_q[CHG_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      winCnt_q <= 3'h0;
    else if (chgSet)
      winCnt_q <= WINDOW_CNT;
    else if (selWr)
      winCnt_q <= 3'h0;
    else if (winCnt_q != 3'h0)
      winCnt_q <= winCnt_q - 3'h1;
  end

  // ---------------------------------------------------------------
  // automatic masking
  // ---------------------------------------------------------------
  mask_state_t maskState_q;
  logic [2:0] tailCnt_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      maskState_q <= MASK_IDLE;
      tailCnt_q <= 3'h0;
    end
    else
    begin
      case (maskState_q)
        MASK_IDLE:
          if (chgSet)
            maskState_q <= MASK_WINDOW;
        MASK_WINDOW:
          if (selWr)
          begin
            maskState_q <= MASK_TAIL;
            tailCnt_q <= TAIL_CNT;
          end
          else if (winCnt_q == 3'h1 && !chgSet)
            maskState_q <= MASK_IDLE;
        MASK_TAIL:
          if (chgSet)
            maskState_q <= MASK_WINDOW;
          else if (instrDone)
          begin
            if (tailCnt_q == 3'h1)
              maskState_q <= MASK_IDLE;
            tailCnt_q <= tailCnt_q - 3'h1;
          end
        default:
          maskState_q <= MASK_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // vector base and section lock
  // ---------------------------------------------------------------
  logic [PC_W-1:0] bootStart;
  logic inBootNow;
  logic lockBlock;
  logic autoMask;

  boot_base uBase
  (
    .bootSize(fuses.bootSize),
    .bootStart(bootStart)
  );

  assign inBootNow = corePc >= bootStart;
  assign lockBlock = ctrl_q[SEL_BIT] ? (fuses.appLock & ~inBootNow)
                                     : (fuses.bootLock & inBootNow);
  // register write sets mask in same cycle as change enable
  assign autoMask = (maskState_q != MASK_IDLE) | chgSet;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      vecOut <= '0;
    else
    begin
      vecOut.vectorBase <= ctrl_q[SEL_BIT] ? bootStart : APP_BASE;
      vecOut.inBoot <= inBootNow;
      // global enable is not an input here, so it is never touched
      vecOut.irqBlock <= autoMask | lockBlock;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  // low while a read answer is pending or about to be raised
  always_ff @(posedge core_clk)
  begin
    if (rst)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= ~(s_axi_arvalid & s_axi_arready) &
                       ~(s_axi_rvalid & ~s_axi_rready);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr[3:2] == CTRL_ADDR[3:2])
        s_axi_rdata <= {24'h000000, ctrl_q & CTRL_WMASK};
      else if (s_axi_araddr[3:2] == STAT_ADDR[3:2])
        s_axi_rdata <= {29'h0000000, inBootNow, lockBlock, autoMask};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_chg_self_clear:
    assert property (@(posedge core_clk) disable iff (rst)
      chgSet |=> ##[0:4] !ctrl_q[CHG_BIT] || chgSet)
    else $error("change enable not cleared in four cycles");
  a_mask_on_set:
    assert property (@(posedge core_clk) disable iff (rst)
      chgSet |=> vecOut.irqBlock)
    else $error("interrupts not masked on change enable");
  a_sel_hold:
    assert property (@(posedge core_clk) disable iff (rst)
      !winOpen |=> $stable(ctrl_q[SEL_BIT]))
    else $error("select changed outside window");
  a_mask_release:
    assert property (@(posedge core_clk) disable iff (rst)
      (chgSet ##1 (!chgSet && !selWr) [*4]) |=> maskState_q == MASK_IDLE)
    else $error("mask not released after four cycles");
  a_base_select:
    assert property (@(posedge core_clk) disable iff (rst)
      ctrl_q[SEL_BIT] |=> vecOut.vectorBase == $past(bootStart))
    else $error("vector base not at boot start");
  a_base_app:
    assert property (@(posedge core_clk) disable iff (rst)
      !ctrl_q[SEL_BIT] |=> vecOut.vectorBase == APP_BASE)
    else $error("vector base not at flash start");
  a_lock_block:
    assert property (@(posedge core_clk) disable iff (rst)
      (ctrl_q[SEL_BIT] && fuses.appLock && !inBootNow) |=> vecOut.irqBlock)
    else $error("application code not blocked");
  a_ro_bits:
    assert property (@(posedge core_clk) disable iff (rst)
      (ctrl_q & ~CTRL_WMASK & 8'hFC) == 8'h00)
    else $error("read-only bits set");
  c_move: cover property (@(posedge core_clk) selWr && wData_q[SEL_BIT]);
  c_timeout: cover property (@(posedge core_clk)
    maskState_q == MASK_WINDOW ##1 maskState_q == MASK_IDLE);
  c_lock: cover property (@(posedge core_clk) lockBlock);

endmodule

// ==== tb/core_model.sv ====
// Purpose: behavioural processor core feeding pc and retire pulses
// Assumes: one clock, synchronous active-high reset
// Notes: retire pulses only while run is high, so a test can stall
`timescale 1ns/10ps
module core_model
  import ivp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [PC_W-1:0] pcSet,
  output logic [PC_W-1:0] corePc,
  output logic instrDone
);
  // ---------------------------------------------------------------
  // fetch and retire
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      corePc <= APP_BASE;
      instrDone <= 1'b0;
    end
    else
    begin
      corePc <= pcSet;
      instrDone <= run & ~instrDone;
    end
  end
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for interrupt vector placement
// Assumes: core_model drives pc and retire pulses
// Notes: AXI4-Lite register traffic, seeded random data
`timescale 1ns/10ps
module tb
  import ivp_pkg::*;
;
  logic core_clk, rst, run, awValid, wValid, bReady, arValid, rReady;
  logic awRdy, wRdy, bValid, arRdy, rValid, instrDone;
  logic [3:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp, resp;
  logic [7:0] q, d;
  logic [PC_W-1:0] pcSet, corePc;
  fuse_t fuses;
  vec_out_t vecOut;
  int errors = 0;
  int samplesChecked = 0;
  int cyc = 0;

  core_model core_model_inst (.core_clk(core_clk), .rst(rst), .run(run),
    .pcSet(pcSet), .corePc(corePc), .instrDone(instrDone));

  interrupt_vector_placement interrupt_vector_placement_inst (
    .core_clk(core_clk), .rst(rst), .fuses(fuses), .corePc(corePc),
    .instrDone(instrDone), .vecOut(vecOut), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awRdy), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arRdy),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize();
    if (errors == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one AXI4-Lite access, entered just after a rising edge
  task automatic xfer(input bit wr, input logic [3:0] a,
    input logic [7:0] dv);
    bit fin, awT, wT, arT;
    fin = 1'b0;
    bReady <= wr;
    rReady <= !wr;
    awAddr <= a;
    arAddr <= a;
    wData <= {24'h000000, dv};
    awValid <= wr;
    wValid <= wr;
    arValid <= !wr;
    while (!fin)
    begin
      @(negedge core_clk);
      awT = awValid && awRdy;
      wT = wValid && wRdy;
      arT = arValid && arRdy;
      fin = wr ? bValid : rValid;
      resp = wr ? bResp : rResp;
      q = rData[7:0];
      @(posedge core_clk);
      if (awT)
        awValid <= 1'b0;
      if (wT)
        wValid <= 1'b0;
      if (arT)
        arValid <= 1'b0;
    end
  endtask

  task automatic moveTo(input logic sel);
    xfer(1'b1, CTRL_ADDR, 8'h01);
    xfer(1'b1, CTRL_ADDR, {6'h00, sel, 1'b0});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  function automatic logic [PC_W-1:0] bootStart(input logic [1:0] bs);
    logic [15:0] v;
    v = 16'h4000 - (16'h0100 << (3 - bs));
    return v[PC_W-1:0];
  endfunction

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    pcSet = APP_BASE;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    awAddr = 4'h0;
    arAddr = 4'h0;
    wData = 32'h00000000;
    void'($urandom(8629));
    fuses = '{bootSize: 2'($urandom), appLock: 1'b0, bootLock: 1'b0};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    wt(1);
    chk(vecOut, 32'h00000000);
    @(posedge core_clk);
    xfer(1'b0, CTRL_ADDR, 8'h00);
    chk(q, CTRL_RESET);
    repeat (4)
    begin
      d = 8'($urandom) & 8'hFE;
      xfer(1'b1, CTRL_ADDR, d);
      xfer(1'b0, CTRL_ADDR, 8'h00);
      chk(q, d & 8'h90);
      @(negedge core_clk);
      chk(vecOut.vectorBase, APP_BASE);
      @(posedge core_clk);
    end
    xfer(1'b1, CTRL_ADDR, 8'h00);
    xfer(1'b1, 4'h8, 8'h01);
    chk(resp, 2'h2);
    xfer(1'b0, 4'hC, 8'h00);
    chk(resp, 2'h2);
    // stalled core: mask must wait for a retire
    moveTo(1'b1);
    wt(2);
    chk(vecOut.vectorBase, bootStart(fuses.bootSize));
    chk(vecOut.irqBlock, 1'b1);
    @(posedge core_clk);
    xfer(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h02);
    @(negedge core_clk);
    chk(vecOut.irqBlock, 1'b1);
    @(posedge core_clk);
    run <= 1'b1;
    wt(6);
    chk(vecOut.irqBlock, 1'b0);
    // every boot size while vectors sit in the boot section
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      fuses.bootSize <= 2'(i);
      wt(2);
      chk(vecOut.vectorBase, bootStart(2'(i)));
    end
    // enable without a select write
    @(posedge core_clk);
    xfer(1'b1, CTRL_ADDR, 8'h03);
    @(negedge core_clk);
    chk(vecOut.irqBlock, 1'b1);
    wt(2);
    chk(vecOut.irqBlock, 1'b1);
    wt(2);
    chk(vecOut.irqBlock, 1'b0);
    @(posedge core_clk);
    xfer(1'b0, CTRL_ADDR, 8'h00);
    chk(q, 8'h02);
    // section lock blocking
    fuses.appLock <= 1'b1;
    wt(3);
    chk(vecOut.irqBlock, 1'b1);
    chk(vecOut.inBoot, 1'b0);
    @(posedge core_clk);
    xfer(1'b0, STAT_ADDR, 8'h00);
    chk(q, 8'h02);
    @(posedge core_clk);
    pcSet <= FLASH_TOP;
    wt(3);
    chk(vecOut.irqBlock, 1'b0);
    chk(vecOut.inBoot, 1'b1);
    @(posedge core_clk);
    fuses.appLock <= 1'b0;
    fuses.bootLock <= 1'b1;
    moveTo(1'b0);
    wt(6);
    chk(vecOut.vectorBase, APP_BASE);
    chk(vecOut.irqBlock, 1'b1);
    @(posedge core_clk);
    pcSet <= APP_BASE;
    wt(3);
    chk(vecOut.irqBlock, 1'b0);
    summarize();
  end
endmodule
